//--- hw/lsr_pkg.sv
// Shared constants and types of the light sensor register bank
package lsr_pkg;
	// Register pointer values
	localparam logic [7:0] PTR_RESULT = 8'h00;
	localparam logic [7:0] PTR_SETUP = 8'h01;
	localparam logic [7:0] PTR_LOWER = 8'h02;
	localparam logic [7:0] PTR_UPPER = 8'h03;
	localparam logic [7:0] PTR_MAKER = 8'h7e;
	localparam logic [7:0] PTR_PART = 8'h7f;
	localparam logic [7:0] PTR_RESET = 8'h00;
	// Field positions of sensor_setup
	localparam int RANGE_MSB = 15;
	localparam int RANGE_LSB = 12;
	localparam int CT_BIT = 11;
	localparam int MODE_MSB = 10;
	localparam int MODE_LSB = 9;
	localparam int OVF_BIT = 8;
	localparam int CRF_BIT = 7;
	localparam int FH_BIT = 6;
	localparam int FL_BIT = 5;
	localparam int MASK_BIT = 2;
	// Field positions of light_result
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 12;
	localparam int MANT_MSB = 11;
	// Reset values and write masks
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] SETUP_RESET = 16'hc810;
	localparam logic [15:0] SETUP_WR_MASK = 16'hfe1f;
	localparam logic [15:0] LOWER_RESET = 16'h0000;
	localparam logic [15:0] UPPER_RESET = 16'hbfff;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	// Identity codes: arbitrary neutral values
	localparam logic [15:0] MAKER_CODE_DEF = 16'h5a5a;
	localparam logic [15:0] PART_CODE_DEF = 16'h0c0d;
	// Range and mode codes
	localparam logic [3:0] RANGE_AUTO = 4'hc;
	localparam logic [3:0] RANGE_MAX = 4'hb;
	localparam logic [3:0] RANGE_MIN = 4'h0;
	localparam logic [3:0] AUTO_START_RANGE = 4'hb;
	localparam logic [1:0] MODE_OFF = 2'b00;
	localparam logic [1:0] MODE_SINGLE = 2'b01;
	localparam logic [11:0] MANT_DOWN_LIMIT = 12'h400;
	// Conversion timing
	localparam int CLK_MHZ = 125;
	localparam int CONV_SHORT_MS = 100;
	localparam int CONV_LONG_MS = 800;
	localparam int CONV_SHORT_CYC = CONV_SHORT_MS * CLK_MHZ * 1000;
	localparam int CONV_LONG_CYC = CONV_LONG_MS * CLK_MHZ * 1000;
	localparam int CNT_W = 27;
	// Phases of an incoming write transaction
	typedef enum logic [1:0] {WP_PTR, WP_MSB, WP_LSB, WP_IDLE} lsr_wphase_t;
endpackage : lsr_pkg

//--- hw/lsr_conv_if.sv
// Handshake between register logic and conversion timer
`timescale 1ns/1ns
interface lsr_conv_if;
	logic start;
	logic abort;
	logic long_sel;
	logic busy;
	logic done;
	modport ctrl (output start, output abort, output long_sel,
		input busy, input done);
	modport eng (input start, input abort, input long_sel,
		output busy, output done);
endinterface : lsr_conv_if

//--- hw/lsr_conv.sv
// Conversion timer: runs one integration period per start
`timescale 1ns/1ns
module lsr_conv #(
	parameter int unsigned SHORT_CYC = 125,
	parameter int unsigned LONG_CYC = 1000
) (
	input wire logic clk_sys,
	input wire logic rst,
	lsr_conv_if.eng cv
);
	import lsr_pkg::*;
	logic busy_q;
	logic done_q;
	logic [CNT_W-1:0] cnt_q;
	wire logic [CNT_W-1:0] load_val;
	wire logic cnt_zero;
	assign load_val = cv.long_sel ? CNT_W'(LONG_CYC - 1) :
		CNT_W'(SHORT_CYC - 1);
	assign cnt_zero = (cnt_q == '0);
	assign cv.busy = busy_q;
	assign cv.done = done_q;
	// Start outranks abort, so a rewrite restarts cleanly
	always_ff @(posedge clk_sys) begin
		done_q <= 1'b0;
		if (rst) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
		end else if (cv.start) begin
			busy_q <= 1'b1;
			cnt_q <= load_val;
		end else if (cv.abort) begin
			busy_q <= 1'b0;
		end else if (busy_q && cnt_zero) begin
			busy_q <= 1'b0;
			done_q <= 1'b1;
		end else if (busy_q) begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end
	done_needs_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
		cv.done |-> $past(busy_q) && !busy_q)
		else $error("done without a running conversion");
endmodule : lsr_conv

//--- hw/lsr_rdmux.sv
// Read selection of the register bank by pointer
`timescale 1ns/1ns
module lsr_rdmux #(
	parameter logic [15:0] MAKER_CODE = 16'h5a5a,
	parameter logic [15:0] PART_CODE = 16'h0c0d
) (
	input wire logic [7:0] ptr,
	input wire logic [15:0] result,
	input wire logic [15:0] setup,
	input wire logic [15:0] lower,
	input wire logic [15:0] upper,
	output logic [15:0] word
);
	import lsr_pkg::*;
	wire logic exp_masked;
	wire logic [15:0] result_view;
	// Mask only in manual range, auto range must show its pick
	assign exp_masked = setup[MASK_BIT] &&
		(setup[RANGE_MSB:RANGE_LSB] < RANGE_AUTO);
	assign result_view = exp_masked ? {4'h0, result[MANT_MSB:0]} :
		result;
	always_comb begin
		if (ptr == PTR_RESULT) begin
			word = result_view;
		end else if (ptr == PTR_SETUP) begin
			word = setup;
		end else if (ptr == PTR_LOWER) begin
			word = lower;
		end else if (ptr == PTR_UPPER) begin
			word = upper;
		end else if (ptr == PTR_MAKER) begin
			word = MAKER_CODE;
		end else if (ptr == PTR_PART) begin
			word = PART_CODE;
		end else begin
			word = UNMAPPED_READ;
		end
	end
endmodule : lsr_rdmux

//--- hw/lsr_regs.sv
// Register bank of the ambient light sensor behind its byte port
// How it works
// - Every register is sixteen bits wide.
// - Pointer 00h result, 01h setup, 02h lower, 03h upper threshold.
// - Pointers 7Eh and 7Fh read fixed maker and part codes.
// - Result is read-only and holds the latest finished conversion.
// - Result packs a 4-bit exponent above a 12-bit mantissa.
// - Result clears to zero at reset.
// - Mantissa is plain unsigned binary from the front end.
// - Each exponent step doubles the weight of one mantissa step.
// - Mask bit with manual range codes below 1100b reports exponent zero.
// - A setup write aborts a running conversion at once.
// - A setup write asking for conversions starts a fresh one.
// - Range field picks the full scale, coded like the exponent.
// - Range code 1100b selects auto range, reported in the exponent.
// - Setup resets to C810h, auto range.
// - Setup bits 15:9 and 4:0 writable, flags 8:5 read-only.
// - Reads return the register of the last written pointer.
// - Words move as two bytes, upper byte first.
// - Mode 01b runs one conversion then reads 00b; 1xb is continuous.
`timescale 1ns/1ns
module lsr_regs #(
	parameter int unsigned CONV_SHORT_CYCLES = lsr_pkg::CONV_SHORT_CYC,
	parameter int unsigned CONV_LONG_CYCLES = lsr_pkg::CONV_LONG_CYC,
	parameter logic [15:0] MAKER_CODE = lsr_pkg::MAKER_CODE_DEF,
	parameter logic [15:0] PART_CODE = lsr_pkg::PART_CODE_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic xfer_start,
	input wire logic wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic rd_start,
	input wire logic rd_req,
	output logic [7:0] rd_byte,
	input wire logic [11:0] afe_mantissa,
	input wire logic afe_overflow,
	output logic [3:0] afe_range,
	output logic afe_active
);
	import lsr_pkg::*;

	lsr_conv_if cv ();

	lsr_wphase_t wphase_q;
	logic [7:0] ptr_q;
	logic [7:0] wr_msb_q;
	logic [15:0] setup_q;
	logic [15:0] setup_d;
	logic [15:0] result_q;
	logic [15:0] lower_q;
	logic [15:0] upper_q;
	logic [3:0] arange_q;
	logic [3:0] arange_d;
	logic [3:0] crange_q;
	logic [15:0] rd_word_q;
	logic rd_lsb_q;
	logic [7:0] rd_byte_q;

	wire logic wr_commit;
	wire logic [15:0] wr_word;
	wire logic setup_wr;
	wire logic lower_wr;
	wire logic upper_wr;
	wire logic [15:0] new_setup;
	wire logic [15:0] src_setup;
	wire logic [1:0] src_mode;
	wire logic [3:0] src_range;
	wire logic conv_end;
	wire logic auto_mode;
	wire logic retry;
	wire logic accept;
	wire logic keep_going;
	wire logic [3:0] start_range;
	wire logic crf_clr;
	wire logic [15:0] mux_word;

	// Write transaction: pointer byte, then upper, then lower
	assign wr_commit = wr_valid && !xfer_start && (wphase_q == WP_LSB);
	assign wr_word = {wr_msb_q, wr_byte};
	assign setup_wr = wr_commit && (ptr_q == PTR_SETUP);
	assign lower_wr = wr_commit && (ptr_q == PTR_LOWER);
	assign upper_wr = wr_commit && (ptr_q == PTR_UPPER);
	// Read-only flag bits keep their value on a write
	assign new_setup = (wr_word & SETUP_WR_MASK) |
		(setup_q & ~SETUP_WR_MASK);

	// Settings in force for any start issued this cycle
	assign src_setup = setup_wr ? new_setup : setup_q;
	assign src_mode = src_setup[MODE_MSB:MODE_LSB];
	assign src_range = src_setup[RANGE_MSB:RANGE_LSB];

	// A rewrite discards the finishing result too
	assign conv_end = cv.done && !setup_wr;
	assign auto_mode = (setup_q[RANGE_MSB:RANGE_LSB] == RANGE_AUTO);
	assign retry = conv_end && auto_mode && afe_overflow &&
		(crange_q != RANGE_MAX);
	assign accept = conv_end && !retry;
	assign keep_going = accept && setup_q[MODE_MSB];

	// Auto range steps up on overflow and down on a weak reading
	always_comb begin
		arange_d = arange_q;
		if (retry) begin
			arange_d = crange_q + 4'h1;
		end else if (accept && auto_mode &&
			afe_mantissa < MANT_DOWN_LIMIT && crange_q != RANGE_MIN) begin
			arange_d = crange_q - 4'h1;
		end
	end
	assign start_range = (src_range == RANGE_AUTO) ? arange_d :
		src_range;

	assign cv.abort = setup_wr && cv.busy;
	assign cv.start = (setup_wr && src_mode != MODE_OFF) || retry ||
		keep_going;
	assign cv.long_sel = src_setup[CT_BIT];

	// Ready flag drops when software reads the setup word
	assign crf_clr = rd_start && (ptr_q == PTR_SETUP);

	always_comb begin
		setup_d = setup_q;
		if (setup_wr) begin
			setup_d = new_setup;
		end else if (accept) begin
			setup_d[OVF_BIT] = afe_overflow;
			if (setup_q[MODE_MSB:MODE_LSB] == MODE_SINGLE) begin
				setup_d[MODE_MSB:MODE_LSB] = MODE_OFF;
			end
		end
		// Set wins over a clear in the same cycle
		if (crf_clr) begin
			setup_d[CRF_BIT] = 1'b0;
		end
		if (accept) begin
			setup_d[CRF_BIT] = 1'b1;
		end
	end

	lsr_conv #(
		.SHORT_CYC(CONV_SHORT_CYCLES),
		.LONG_CYC(CONV_LONG_CYCLES)
	) u_conv (
		.clk_sys(clk_sys),
		.rst(rst),
		.cv(cv)
	);

	lsr_rdmux #(
		.MAKER_CODE(MAKER_CODE),
		.PART_CODE(PART_CODE)
	) u_rdmux (
		.ptr(ptr_q),
		.result(result_q),
		.setup(setup_q),
		.lower(lower_q),
		.upper(upper_q),
		.word(mux_word)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wphase_q <= WP_IDLE;
		end else if (xfer_start) begin
			wphase_q <= WP_PTR;
		end else if (wr_valid) begin
			case (wphase_q)
			WP_PTR: wphase_q <= WP_MSB;
			WP_MSB: wphase_q <= WP_LSB;
			default: wphase_q <= WP_IDLE;
			endcase
		end
	end

	// Pointer survives reads, only a pointer byte moves it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ptr_q <= PTR_RESET;
		end else if (wr_valid && !xfer_start && wphase_q == WP_PTR) begin
			ptr_q <= wr_byte;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_msb_q <= 8'h00;
		end else if (wr_valid && !xfer_start && wphase_q == WP_MSB) begin
			wr_msb_q <= wr_byte;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setup_q <= SETUP_RESET;
		end else begin
			setup_q <= setup_d;
		end
	end

	// Result only moves on an accepted conversion, never on a write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			result_q <= RESULT_RESET;
		end else if (accept) begin
			result_q <= {crange_q, afe_mantissa};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lower_q <= LOWER_RESET;
		end else if (lower_wr) begin
			lower_q <= wr_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			upper_q <= UPPER_RESET;
		end else if (upper_wr) begin
			upper_q <= wr_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			arange_q <= AUTO_START_RANGE;
			crange_q <= RANGE_MIN;
		end else begin
			arange_q <= arange_d;
			if (cv.start) begin
				crange_q <= start_range;
			end
		end
	end

	// Word is frozen at read start so both bytes belong together
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_word_q <= 16'h0000;
			rd_lsb_q <= 1'b0;
			rd_byte_q <= 8'h00;
		end else if (rd_start) begin
			rd_word_q <= mux_word;
			rd_lsb_q <= 1'b0;
		end else if (rd_req) begin
			rd_byte_q <= rd_lsb_q ? rd_word_q[7:0] :
				rd_word_q[15:8];
			rd_lsb_q <= !rd_lsb_q;
		end
	end

	assign rd_byte = rd_byte_q;
	assign afe_range = crange_q;
	// Front end powered only while a conversion runs
	assign afe_active = cv.busy;

	result_reset_a: assert property (@(posedge clk_sys)
		rst |=> result_q == 16'h0000)
		else $error("result not cleared by reset");

	setup_reset_a: assert property (@(posedge clk_sys)
		rst |=> setup_q == 16'hc810)
		else $error("setup not at its reset value");

	ro_flags_kept_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		setup_wr && !crf_clr |=> setup_q[8:5] == $past(setup_q[8:5]))
		else $error("setup write changed a read-only flag");

	rw_bits_take_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		setup_wr |=> (setup_q & 16'hfe1f) == ($past(wr_word) & 16'hfe1f))
		else $error("writable setup bits not updated");

	write_aborts_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		setup_wr && new_setup[10:9] == 2'b00 |=> !cv.busy && !accept)
		else $error("conversion survived a setup write");

	write_restarts_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		setup_wr && new_setup[10:9] != 2'b00 |=> cv.busy)
		else $error("no fresh conversion after setup write");

	single_ends_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		accept && setup_q[10:9] == 2'b01 |=> setup_q[10:9] == 2'b00
		&& !cv.busy)
		else $error("single conversion did not return to shutdown");

	cont_runs_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		accept && setup_q[10] |=> cv.busy ##1 (cv.busy || $past(setup_wr)))
		else $error("continuous mode stopped");

	auto_exp_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		accept |=> result_q[15:12] == $past(crange_q)
		&& result_q[11:0] == $past(afe_mantissa))
		else $error("result does not carry range and mantissa");

	mask_exp_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		ptr_q == 8'h00 && setup_q[2] && setup_q[15:12] < 4'hc
		|-> mux_word[15:12] == 4'h0)
		else $error("exponent shown while masked");

	id_codes_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		rd_start && ptr_q == 8'h7f ##1 rd_req ##1 rd_req
		|=> {$past(rd_byte_q), rd_byte_q} == PART_CODE)
		else $error("part code not returned upper byte first");

	byte_order_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		rd_req && !rd_start && !rd_lsb_q |=> rd_byte_q == rd_word_q[15:8])
		else $error("upper byte not sent first");

	ptr_kept_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		rd_start || rd_req |=> $stable(ptr_q))
		else $error("pointer moved during a read");

	ready_set_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		accept |=> setup_q[7])
		else $error("ready flag lost on a finished conversion");

	range_pick_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		cv.start && src_range != RANGE_AUTO |=> crange_q == $past(src_range))
		else $error("manual range not used for the conversion");

	auto_step_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		retry |=> cv.busy && crange_q == $past(crange_q) + 4'h1)
		else $error("auto range did not step up on overflow");

	thresh_write_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		lower_wr |=> lower_q == $past(wr_word))
		else $error("lower threshold write lost");

	result_hold_a: assert property (@(posedge clk_sys)
		disable iff (rst)
		!accept |=> $stable(result_q))
		else $error("result moved without a finished conversion");
endmodule : lsr_regs

//--- test/lsr_afe_model.sv
// Light front-end model driving the mantissa and overflow inputs
`timescale 1ns/1ns
module lsr_afe_model (
	input wire logic clk_sys,
	input wire logic [3:0] afe_range,
	input wire logic afe_active,
	input wire logic [23:0] light,
	output logic [11:0] afe_mantissa,
	output logic afe_overflow
);
	logic act_q = 1'b0;
	logic [11:0] junk_q = 12'h5a5;
	// Light in finest steps, halved once per range code
	wire logic [23:0] scaled = light >> afe_range;
	wire logic over = scaled > 24'h000fff;
	// Valid only around a conversion, junk otherwise
	wire logic live = afe_active | act_q;
	always_ff @(posedge clk_sys) begin
		act_q <= afe_active;
		junk_q <= junk_q + 12'h9e3;
	end
	// Saturates at full scale, plain binary count
	assign afe_mantissa = !live ? junk_q :
		over ? 12'hfff : scaled[11:0];
	assign afe_overflow = live ? over : junk_q[0];
endmodule : lsr_afe_model

//--- test/lsr_regs_tb_top.sv
// Testbench of the light sensor register bank
`timescale 1ns/1ns
module lsr_regs_tb_top;
	import lsr_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic xfer_start = 1'b0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_byte = 8'h00;
	logic rd_start = 1'b0;
	logic rd_req = 1'b0;
	logic [7:0] rd_byte;
	logic [11:0] afe_mantissa;
	logic afe_overflow;
	logic [3:0] afe_range;
	logic afe_active;
	logic [23:0] light = 24'h000000;
	logic [15:0] w;
	int n_mismatch = 0;
	int n_checks = 0;

	always #4 clk_sys = ~clk_sys;

	// Short counts keep the run brief
	lsr_regs #(.CONV_SHORT_CYCLES(20), .CONV_LONG_CYCLES(50)) i_dut (
		.clk_sys(clk_sys),
		.rst(rst),
		.xfer_start(xfer_start),
		.wr_valid(wr_valid),
		.wr_byte(wr_byte),
		.rd_start(rd_start),
		.rd_req(rd_req),
		.rd_byte(rd_byte),
		.afe_mantissa(afe_mantissa),
		.afe_overflow(afe_overflow),
		.afe_range(afe_range),
		.afe_active(afe_active)
	);

	lsr_afe_model i_afe (
		.clk_sys(clk_sys),
		.afe_range(afe_range),
		.afe_active(afe_active),
		.light(light),
		.afe_mantissa(afe_mantissa),
		.afe_overflow(afe_overflow)
	);

	task final_report;
		$display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task check(input string n, input logic [15:0] seen, input logic [15:0] e);
		n_checks++;
		if (seen !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, seen);
		end
	endtask : check

	// Pointer-only write
	task set_ptr(input logic [7:0] p);
		@(posedge clk_sys) xfer_start <= 1'b1;
		@(posedge clk_sys) begin
			xfer_start <= 1'b0;
			wr_valid <= 1'b1;
			wr_byte <= p;
		end
		@(posedge clk_sys) wr_valid <= 1'b0;
	endtask : set_ptr

	// Upper byte goes first on the wire
	task wr_reg(input logic [7:0] p, input logic [15:0] d);
		@(posedge clk_sys) xfer_start <= 1'b1;
		@(posedge clk_sys) begin
			xfer_start <= 1'b0;
			wr_valid <= 1'b1;
			wr_byte <= p;
		end
		@(posedge clk_sys) wr_byte <= d[15:8];
		@(posedge clk_sys) wr_byte <= d[7:0];
		@(posedge clk_sys) wr_valid <= 1'b0;
		@(negedge clk_sys);
	endtask : wr_reg

	task rd_word(output logic [15:0] d);
		@(posedge clk_sys) rd_start <= 1'b1;
		@(posedge clk_sys) begin
			rd_start <= 1'b0;
			rd_req <= 1'b1;
		end
		@(posedge clk_sys);
		@(negedge clk_sys) d[15:8] = rd_byte;
		@(posedge clk_sys) rd_req <= 1'b0;
		@(negedge clk_sys) d[7:0] = rd_byte;
	endtask : rd_word

	task rd_chk(input string n, input logic [7:0] p, input logic [15:0] e);
		set_ptr(p);
		rd_word(w);
		check(n, w, e);
	endtask : rd_chk

	// Bounded wait for the conversion timer to stop
	task wait_idle;
		for (int i = 0; i < 200; i++) begin
			@(negedge clk_sys);
			if (afe_active === 1'b0) begin
				break;
			end
		end
		if (afe_active !== 1'b0) begin
			n_mismatch++;
			$display("[ERR] afe_active expected 0 seen %b", afe_active);
			final_report();
		end
	endtask : wait_idle

	initial begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset contents and the default pointer
		rd_word(w);
		check("default ptr", w, RESULT_RESET);
		rd_chk("setup rst", PTR_SETUP, SETUP_RESET);
		rd_chk("lower rst", PTR_LOWER, LOWER_RESET);
		rd_chk("upper rst", PTR_UPPER, UPPER_RESET);
		rd_chk("maker", PTR_MAKER, MAKER_CODE_DEF);
		rd_chk("part", PTR_PART, PART_CODE_DEF);
		rd_word(w);
		check("ptr kept", w, PART_CODE_DEF);
		// Threshold words and an unmapped place
		wr_reg(PTR_LOWER, 16'h5abc);
		wr_reg(PTR_UPPER, 16'h3fff);
		wr_reg(8'h04, 16'hffff);
		rd_chk("lower", PTR_LOWER, 16'h5abc);
		rd_chk("upper", PTR_UPPER, 16'h3fff);
		rd_chk("unmapped", 8'h04, UNMAPPED_READ);
		// Writes at read-only places and bits
		wr_reg(PTR_RESULT, 16'h1234);
		wr_reg(PTR_MAKER, 16'h1111);
		rd_chk("result ro", PTR_RESULT, RESULT_RESET);
		rd_chk("maker ro", PTR_MAKER, MAKER_CODE_DEF);
		wr_reg(PTR_SETUP, 16'h31e4);
		rd_chk("setup flags", PTR_SETUP, 16'h3004);
		// Single shot on manual range three
		light <= 24'h0022b0;
		wr_reg(PTR_SETUP, 16'h3200);
		check("start", {15'h0, afe_active}, 16'h0001);
		check("range", {12'h0, afe_range}, 16'h0003);
		rd_chk("mode busy", PTR_SETUP, 16'h3200);
		wait_idle();
		rd_chk("result", PTR_RESULT, 16'h3456);
		rd_chk("mode done", PTR_SETUP, 16'h3080);
		// Mask hides the exponent of a manual range
		wr_reg(PTR_SETUP, 16'h3204);
		wait_idle();
		rd_chk("masked", PTR_RESULT, 16'h0456);
		rd_chk("setup me", PTR_SETUP, 16'h3084);
		// Abort a long conversion by a setup write
		light <= 24'h000100;
		wr_reg(PTR_SETUP, 16'h5a00);
		repeat (10) @(negedge clk_sys);
		wr_reg(PTR_SETUP, 16'h2000);
		check("aborted", {15'h0, afe_active}, 16'h0000);
		repeat (60) @(negedge clk_sys);
		rd_chk("discarded", PTR_RESULT, 16'h3456);
		// Auto range steps down while the light is dim
		// Codes 1101b to 1111b are never written here
		// Mask set, but auto range still shows its exponent
		light <= 24'h010000;
		wr_reg(PTR_SETUP, 16'hc404);
		repeat (300) @(negedge clk_sys);
		rd_chk("auto down", PTR_RESULT, 16'h6400);
		check("auto range", {12'h0, afe_range}, 16'h0006);
		// Bright light climbs to the top range and overflows
		light <= 24'h800000;
		repeat (300) @(negedge clk_sys);
		rd_chk("auto top", PTR_RESULT, 16'hbfff);
		rd_chk("overflow", PTR_SETUP, 16'hc584);
		// Manual range four, long time, mode 11 keeps converting
		wr_reg(PTR_SETUP, 16'h4e00);
		light <= 24'h0022b0;
		repeat (25) @(negedge clk_sys);
		rd_chk("long pending", PTR_RESULT, 16'hbfff);
		repeat (100) @(negedge clk_sys);
		check("cont busy", {15'h0, afe_active}, 16'h0001);
		rd_chk("cont 11", PTR_RESULT, 16'h422b);
		rd_chk("mode cont", PTR_SETUP, 16'h4e80);
		wr_reg(PTR_SETUP, 16'hc000);
		wait_idle();
		final_report();
	end
endmodule : lsr_regs_tb_top
